// ===== core/ssr_regs.svh
// Purpose: Shared constants of the five-unit start-stop receiver
// Assumes: Included by bare name from the receiver, the assertion file and the bench
// Notes: Times are in microseconds, counts derive from the clock rate
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define SSR_CLK_MHZ 20

// ----------------------------------------------------------------
// Unit intervals per speed setting, microseconds
// ----------------------------------------------------------------
`define SSR_UI0_US 22000
`define SSR_UI1_US 20000
`define SSR_UI2_US 17500
`define SSR_UI3_US 13500

// ----------------------------------------------------------------
// Long stop element is 1.42 units
// ----------------------------------------------------------------
`define SSR_STOP_NUM 142
`define SSR_STOP_DEN 100

// ----------------------------------------------------------------
// Code layout and shift codes
// ----------------------------------------------------------------
`define SSR_CODE_W 5
`define SSR_LAST_ELEM 3'h4
`define SSR_LTRS_CODE 5'h1f
`define SSR_FIGS_CODE 5'h1b
`define SSR_FIFO_DEPTH 4

`endif

// ===== core/ssr_pkg.sv
// Purpose: Types of the five-unit start-stop receiver
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: State codes are one-hot
`default_nettype none

package ssr_pkg;

  typedef enum logic [4:0]
  {
    SEL_IDLE  = 5'h01,
    SEL_START = 5'h02,
    SEL_DATA  = 5'h04,
    SEL_STOP  = 5'h08,
    SEL_REST  = 5'h10
  } ssr_sel_e;

  typedef enum logic [2:0]
  {
    FN_IDLE  = 3'h1,
    FN_PUNCH = 3'h2,
    FN_ADV   = 3'h4
  } ssr_fn_e;

endpackage

`default_nettype wire

// ===== core/ssr_code_if.sv
// Purpose: Valid/ready code stream between receiver modules
// Assumes: One clock, transfer when valid and ready are both high
// Notes: Data must hold while valid waits for ready
`default_nettype none

interface ssr_code_if #(
  parameter int W = 5
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== core/ssr_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin inputs
// Assumes: Synchronous active-low reset
// Notes: First stage feeds only the second
`default_nettype none

module ssr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

`default_nettype wire

// ===== core/ssr_fifo.sv
// Purpose: Small code FIFO between selecting and function cycles
// Assumes: Write and read through valid/ready interfaces
// Notes: Full and empty are exact; DEPTH is a power of two
`default_nettype none

module ssr_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Streams
  ssr_code_if.snk wr,
  ssr_code_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data = mem[rp];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd.valid && rd.ready;

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wp] <= wr.data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end
    else
    begin
      if (do_wr)
        wp <= wp + 1'b1;
      if (do_rd)
        rp <= rp + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== core/ssr_rx.sv
// Purpose: Five-unit start-stop receiver with tape function cycle
// Assumes: Line input high while marking; one 20 MHz clock
// Notes: Selector latches speed and pattern at each start transition; punch length reads the live speed
`include "ssr_regs.svh"
`default_nettype none

// Contract
// - Idle line marks; marking means idle
// - Start spacing, five elements, stop marking
// - Long stop 1.42 units, frame 7.42
// - Short pattern: stop one unit, 7.00
// - 32 codes, letters/figures doubles meaning
// - Shift codes set letters or figures state
// - Unit interval is reciprocal of baud
// - Slowest speed: 45.5 baud, 22 ms unit
// - Also 20, 17.5, 13.5 ms selectable
// - Both ends need equal unit pulse length
// - Start transition launches one selecting cycle
// - Near cycle end, hand code, trigger function
// - Stop ends cycle; ignore line until start
// - Function cycle lags one character behind
// - Function punches holes, feed hole, advances
module ssr_rx import ssr_pkg::*; #(
  parameter int UI0_CYC = `SSR_UI0_US * `SSR_CLK_MHZ,
  parameter int UI1_CYC = `SSR_UI1_US * `SSR_CLK_MHZ,
  parameter int UI2_CYC = `SSR_UI2_US * `SSR_CLK_MHZ,
  parameter int UI3_CYC = `SSR_UI3_US * `SSR_CLK_MHZ,
  parameter int CNT_W = 20,
  parameter int FIFO_DEPTH = `SSR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Signal line, high while marking
  input wire logic LINE_MARK,
  // Speed and pattern selection
  input wire logic [1:0] SPEED_SEL,
  input wire logic PATTERN_742,
  // Tape mechanism
  input wire logic PUNCH_READY,
  output logic [4:0] HOLE,
  output logic FEED_HOLE,
  output logic TAPE_ADV,
  // Decoded characters
  output logic CHAR_VALID,
  output logic [5:0] CHAR_CODE,
  output logic FIGS,
  // Status
  output logic SEL_BUSY,
  output logic FRAME_ERR,
  output logic OVERRUN
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = `SSR_CODE_W;

  logic line_s;
  logic line_d;
  logic [1:0] speed_s;
  logic pat742_s;
  logic punch_ready_s;
  logic start_edge;

  ssr_sel_e sel_state;
  logic [CNT_W-1:0] sel_cnt;
  logic [2:0] elem_idx;
  logic [CW-1:0] shreg;
  logic [CNT_W-1:0] ui_len;
  logic [CNT_W-1:0] rest_len;
  logic stop_ok;

  logic [CNT_W-1:0] tab_ui;
  logic [CNT_W-1:0] tab_stop;

  logic pend_valid;
  logic [CW-1:0] pend_code;

  ssr_fn_e fn_state;
  logic [CNT_W-1:0] fn_cnt;
  logic fn_take;
  logic figs;

  ssr_code_if #(.W(CW)) c_in ();
  ssr_code_if #(.W(CW)) c_out ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Line resets to marking so reset does not look like a start
  ssr_sync #(
    .W(5),
    .INIT(5'h10)
  ) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d({LINE_MARK, SPEED_SEL, PATTERN_742, PUNCH_READY}),
    .q({line_s, speed_s, pat742_s, punch_ready_s})
  );

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      line_d <= 1'b1;
    else
      line_d <= line_s;
  end

  // Only a mark-to-space edge leaves idle
  assign start_edge = line_d && !line_s;

  // ----------------------------------------------------------------
  // Speed table
  // ----------------------------------------------------------------
  // Unit interval in cycles per speed
  always_comb
  begin
    unique case (speed_s)
      2'h0: tab_ui = CNT_W'(UI0_CYC);
      2'h1: tab_ui = CNT_W'(UI1_CYC);
      2'h2: tab_ui = CNT_W'(UI2_CYC);
      2'h3: tab_ui = CNT_W'(UI3_CYC);
    endcase
  end

  // Stop length; the product is formed wide before the cut
  always_comb
  begin
    if (pat742_s)
      tab_stop = CNT_W'((32'(tab_ui) * `SSR_STOP_NUM) / `SSR_STOP_DEN);
    else
      tab_stop = tab_ui;
  end

  // ----------------------------------------------------------------
  // Selecting cycle
  // ----------------------------------------------------------------
  assign stop_ok = (sel_state == SEL_STOP) && (sel_cnt == '0) && line_s;

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      sel_state <= SEL_IDLE;
      sel_cnt <= '0;
      elem_idx <= '0;
      shreg <= '0;
      ui_len <= '0;
      rest_len <= '0;
      FRAME_ERR <= 1'b0;
    end
    else
    begin
      FRAME_ERR <= 1'b0;
      if (sel_cnt != '0)
        sel_cnt <= sel_cnt - 1'b1;
      unique case (sel_state)
        SEL_IDLE:
        begin
          if (start_edge)
          begin
            ui_len <= tab_ui;
            rest_len <= tab_stop - (tab_ui >> 1);
            // Wait half a unit to mid-start
            sel_cnt <= (tab_ui >> 1) - 1'b1;
            sel_state <= SEL_START;
          end
        end
        SEL_START:
        begin
          if (sel_cnt == '0)
          begin
            if (!line_s)
            begin
              sel_cnt <= ui_len - 1'b1;
              elem_idx <= '0;
              sel_state <= SEL_DATA;
            end
            else
              sel_state <= SEL_IDLE;
          end
        end
        SEL_DATA:
        begin
          if (sel_cnt == '0)
          begin
            shreg <= {line_s, shreg[CW-1:1]};
            sel_cnt <= ui_len - 1'b1;
            if (elem_idx == `SSR_LAST_ELEM)
              sel_state <= SEL_STOP;
            else
              elem_idx <= elem_idx + 1'b1;
          end
        end
        SEL_STOP:
        begin
          if (sel_cnt == '0)
          begin
            if (line_s)
            begin
              // Line ignored to the stop's end
              sel_cnt <= rest_len - 1'b1;
              sel_state <= SEL_REST;
            end
            else
            begin
              FRAME_ERR <= 1'b1;
              sel_state <= SEL_IDLE;
            end
          end
        end
        SEL_REST:
        begin
          if (sel_cnt == '0)
            sel_state <= SEL_IDLE;
        end
        default:
          sel_state <= SEL_IDLE;
      endcase
    end
  end

  assign SEL_BUSY = (sel_state != SEL_IDLE);

  // ----------------------------------------------------------------
  // Hand-over to the function side
  // ----------------------------------------------------------------
  // A full FIFO stalls the handover; a second code then is lost
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      pend_valid <= 1'b0;
      pend_code <= '0;
      OVERRUN <= 1'b0;
    end
    else
    begin
      OVERRUN <= 1'b0;
      if (stop_ok && pend_valid && !c_in.ready)
        OVERRUN <= 1'b1;
      else if (stop_ok)
      begin
        // Code goes on near the cycle's end
        pend_valid <= 1'b1;
        pend_code <= shreg;
      end
      else if (c_in.ready)
        pend_valid <= 1'b0;
    end
  end

  assign c_in.valid = pend_valid;
  assign c_in.data = pend_code;

  ssr_fifo #(
    .WIDTH(CW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_b(RST_B),
    .wr(c_in),
    .rd(c_out)
  );

  // ----------------------------------------------------------------
  // Function cycle
  // ----------------------------------------------------------------
  // Runs behind the selector, overlapping the next code
  assign c_out.ready = (fn_state == FN_IDLE) && punch_ready_s;
  assign fn_take = c_out.valid && c_out.ready;

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      fn_state <= FN_IDLE;
      fn_cnt <= '0;
      HOLE <= '0;
      FEED_HOLE <= 1'b0;
      TAPE_ADV <= 1'b0;
    end
    else
    begin
      TAPE_ADV <= 1'b0;
      if (fn_cnt != '0)
        fn_cnt <= fn_cnt - 1'b1;
      unique case (fn_state)
        FN_IDLE:
        begin
          if (fn_take)
          begin
            // Holes held until the next code; feed hole for one unit
            HOLE <= c_out.data;
            FEED_HOLE <= 1'b1;
            fn_cnt <= tab_ui - 1'b1;
            fn_state <= FN_PUNCH;
          end
        end
        FN_PUNCH:
        begin
          if (fn_cnt == '0)
          begin
            FEED_HOLE <= 1'b0;
            TAPE_ADV <= 1'b1;
            fn_state <= FN_ADV;
          end
        end
        FN_ADV:
          fn_state <= FN_IDLE;
        default:
          fn_state <= FN_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Letters/figures shift
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      figs <= 1'b0;
    else if (fn_take)
    begin
      if (c_out.data == `SSR_LTRS_CODE)
        figs <= 1'b0;
      else if (c_out.data == `SSR_FIGS_CODE)
        figs <= 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      CHAR_VALID <= 1'b0;
      CHAR_CODE <= '0;
    end
    else
    begin
      CHAR_VALID <= 1'b0;
      // Other codes read through the shift state
      if (fn_take && c_out.data != `SSR_LTRS_CODE &&
          c_out.data != `SSR_FIGS_CODE)
      begin
        CHAR_VALID <= 1'b1;
        CHAR_CODE <= {figs, c_out.data};
      end
    end
  end

  assign FIGS = figs;

endmodule

`default_nettype wire

// ===== dv/ssr_rx_asserts.sv
// Purpose: Port checks for the start-stop receiver
// Assumes: Speed held steady while a code is punched
// Notes: Bound onto every ssr_rx instance
`include "ssr_regs.svh"
`default_nettype none
module ssr_rx_chk #(
  parameter int UI0_CYC = 40,
  parameter int UI1_CYC = 36,
  parameter int UI2_CYC = 32,
  parameter int UI3_CYC = 24
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Line and speed
  input wire logic LINE_MARK,
  input wire logic [1:0] SPEED_SEL,
  // Outputs
  input wire logic [4:0] HOLE,
  input wire logic FEED_HOLE,
  input wire logic TAPE_ADV,
  input wire logic CHAR_VALID,
  input wire logic [5:0] CHAR_CODE,
  input wire logic FIGS,
  input wire logic SEL_BUSY,
  input wire logic FRAME_ERR,
  input wire logic OVERRUN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] fcnt;
  logic [19:0] ui_exp;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  function automatic logic [19:0] ui_of(input logic [1:0] s);
    case (s)
      2'h0: return 20'(UI0_CYC);
      2'h1: return 20'(UI1_CYC);
      2'h2: return 20'(UI2_CYC);
      default: return 20'(UI3_CYC);
    endcase
  endfunction
  // Length of the current punch phase so far
  always_ff @(posedge CLK)
  begin
    if (!RST_B || !FEED_HOLE)
      fcnt <= '0;
    else
      fcnt <= fcnt + 20'h1;
  end
  // Frozen while punching; speed is taken at the take cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      ui_exp <= '0;
    else if (!FEED_HOLE)
      ui_exp <= ui_of(SPEED_SEL);
  end
  sequence s_punch_go;
    !FEED_HOLE ##1 FEED_HOLE;
  endsequence
  sequence s_feed_end;
    FEED_HOLE ##1 !FEED_HOLE;
  endsequence
  a_feed_len: assert property (s_feed_end
    |-> fcnt == ui_exp && TAPE_ADV)
    else $error("feed hole length or advance wrong");
  a_adv_pulse: assert property (TAPE_ADV |=> !TAPE_ADV && !FEED_HOLE)
    else $error("tape advance not a lone pulse");
  a_char_hole: assert property (CHAR_VALID |-> $rose(FEED_HOLE)
    && CHAR_CODE[4:0] == HOLE ##1 !CHAR_VALID)
    else $error("char strobe not tied to punch");
  a_figs_set: assert property (s_punch_go ##0 HOLE == `SSR_FIGS_CODE
    |-> FIGS && !CHAR_VALID)
    else $error("figures code mishandled");
  a_ltrs_set: assert property (s_punch_go ##0 HOLE == `SSR_LTRS_CODE
    |-> !FIGS && !CHAR_VALID)
    else $error("letters code mishandled");
  a_plain_char: assert property (s_punch_go ##0 HOLE != `SSR_FIGS_CODE
    && HOLE != `SSR_LTRS_CODE |-> CHAR_VALID && CHAR_CODE[5] == FIGS)
    else $error("plain code without strobe");
  a_idle_quiet: assert property ((!SEL_BUSY && LINE_MARK)[*6] |=> !SEL_BUSY)
    else $error("busy on a marking line");
  a_start_busy: assert property ($rose(SEL_BUSY) |-> !LINE_MARK
    ##1 SEL_BUSY[*8])
    else $error("busy without spacing start");
  a_ferr_idle: assert property (FRAME_ERR |=> !FRAME_ERR ##1 !SEL_BUSY)
    else $error("frame error not followed by idle");
  a_ovr_pulse: assert property (OVERRUN |=> !OVERRUN)
    else $error("overrun not a pulse");
endmodule
bind ssr_rx ssr_rx_chk #(.UI0_CYC(UI0_CYC), .UI1_CYC(UI1_CYC),
  .UI2_CYC(UI2_CYC), .UI3_CYC(UI3_CYC)) chk_i (.CLK(CLK), .RST_B(RST_B),
  .LINE_MARK(LINE_MARK), .SPEED_SEL(SPEED_SEL), .HOLE(HOLE),
  .FEED_HOLE(FEED_HOLE), .TAPE_ADV(TAPE_ADV), .CHAR_VALID(CHAR_VALID),
  .CHAR_CODE(CHAR_CODE), .FIGS(FIGS), .SEL_BUSY(SEL_BUSY),
  .FRAME_ERR(FRAME_ERR), .OVERRUN(OVERRUN));
`default_nettype wire

// ===== dv/ssr_line_tx.sv
// Purpose: Remote start-stop transmitter on the signal line
// Assumes: Tasks entered 5 ns after a rising clock edge
// Notes: Current loop, always driven; marking is 1
`default_nettype none
module ssr_line_tx (
  // Clock and line
  input wire logic clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line = 1'b1;
  task automatic hold(input logic lvl, input int n);
    line = lvl;
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic send(input logic [4:0] c, input int ui, input bit lng,
    input bit bad, input int gap);
    if (gap > 0)
      hold(1'b1, gap);
    hold(1'b0, ui);
    for (int i = 0; i < 5; i++)
      hold(c[i], ui);
    hold(!bad, lng ? ui * 142 / 100 : ui);
    line = 1'b1;
  endtask
  task automatic glitch(input int n);
    hold(1'b0, n);
    line = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Purpose: Self-checking bench for the start-stop receiver
// Assumes: Short unit counts; speed held while punching
// Notes: Punch results are judged on falling edges
`include "ssr_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UI_TAB [4] = '{40, 36, 32, 24};
  logic clk, rst_b, pattern_742, punch_ready, feed_q, figs_m;
  logic [1:0] speed_sel;
  wire logic line_mark;
  logic [4:0] hole;
  logic feed_hole, tape_adv, char_valid, figs, sel_busy, frame_err, overrun;
  logic [5:0] char_code;
  logic [4:0] exp_q [$];
  int mismatches, checked, adv_n, ovr_n, ferr_n;

  ssr_rx #(.UI0_CYC(40), .UI1_CYC(36), .UI2_CYC(32), .UI3_CYC(24)) dut (
    .CLK(clk), .RST_B(rst_b), .LINE_MARK(line_mark), .SPEED_SEL(speed_sel),
    .PATTERN_742(pattern_742), .PUNCH_READY(punch_ready), .HOLE(hole),
    .FEED_HOLE(feed_hole), .TAPE_ADV(tape_adv), .CHAR_VALID(char_valid),
    .CHAR_CODE(char_code), .FIGS(figs), .SEL_BUSY(sel_busy),
    .FRAME_ERR(frame_err), .OVERRUN(overrun));
  ssr_line_tx tx (.clk(clk), .line(line_mark));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic punch_chk;
    logic [4:0] c;
    logic sh;
    chk(exp_q.size() > 0, "unexpected punch");
    if (exp_q.size() == 0)
      return;
    c = exp_q.pop_front();
    sh = c == `SSR_FIGS_CODE || c == `SSR_LTRS_CODE;
    chk(hole === c, "hole pattern");
    chk(char_valid === !sh, "char strobe");
    if (!sh)
      chk(char_code === {figs_m, c}, "char code");
    if (c == `SSR_FIGS_CODE)
      figs_m = 1'b1;
    if (c == `SSR_LTRS_CODE)
      figs_m = 1'b0;
    chk(figs === figs_m, "shift state");
  endtask
  always @(negedge clk)
  begin
    if (rst_b && feed_hole && !feed_q)
      punch_chk;
    if (tape_adv === 1'b1)
      adv_n++;
    if (overrun === 1'b1)
      ovr_n++;
    if (frame_err === 1'b1)
      ferr_n++;
    feed_q = feed_hole;
  end
  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() > 0 || feed_hole !== 1'b0) && n < 3000)
    begin
      @(posedge clk);
      #5;
      n++;
    end
    chk(n < 3000, "punch stalled");
    repeat (2) @(posedge clk);
    #5;
  endtask
  task automatic frame(input logic [4:0] c, input bit bad, input bit keep,
    input int gap);
    if (keep)
      exp_q.push_back(c);
    tx.send(c, UI_TAB[speed_sel], pattern_742, bad, gap);
  endtask
  task automatic mode(input int s, input bit p);
    speed_sel = 2'(s);
    pattern_742 = p;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_speeds;
    logic [4:0] cs [8];
    cs = '{5'h00, 5'h1e, 5'h01, 5'h10, 5'h15, 5'h0a, 5'h03, 5'h18};
    for (int i = 0; i < 8; i++)
    begin
      mode(i / 2, i[0]);
      frame(cs[i], 1'b0, 1'b1, 40);
      drain;
    end
    chk(adv_n === 8, "advance count");
  endtask
  task automatic s_shift;
    mode(1, 1'b0);
    frame(`SSR_FIGS_CODE, 1'b0, 1'b1, 8);
    frame(5'h05, 1'b0, 1'b1, 8);
    frame(`SSR_LTRS_CODE, 1'b0, 1'b1, 8);
    frame(5'h05, 1'b0, 1'b1, 8);
    drain;
    chk(figs === 1'b0, "letters at end");
  endtask
  task automatic s_overrun;
    int a;
    a = adv_n;
    mode(3, 1'b1);
    punch_ready = 1'b0;
    for (int i = 1; i <= 6; i++)
      frame(5'(i), 1'b0, i < 6, 8);
    chk(ovr_n === 1, "overrun pulse");
    chk(adv_n === a, "punched while stalled");
    punch_ready = 1'b1;
    drain;
    chk(adv_n === a + 5, "buffered codes");
  endtask
  task automatic s_ferr;
    mode(2, 1'b1);
    frame(5'h07, 1'b1, 1'b0, 32);
    chk(ferr_n === 1, "frame error");
    frame(5'h09, 1'b0, 1'b1, 32);
    drain;
  endtask
  task automatic s_glitch;
    int a;
    a = adv_n;
    mode(0, 1'b1);
    tx.glitch(10);
    repeat (60) @(posedge clk);
    #5;
    chk(sel_busy === 1'b0, "short spacing kept busy");
    chk(adv_n === a && ferr_n === 1, "short spacing output");
    frame(5'h11, 1'b0, 1'b1, 8);
    drain;
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    mode(0, 1'b1);
    punch_ready = 1'b1;
    figs_m = 1'b0;
    feed_q = 1'b0;
    repeat (20) @(posedge clk);
    #5;
    rst_b = 1'b1;
    s_speeds;
    s_shift;
    s_overrun;
    s_ferr;
    s_glitch;
    report_and_stop;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
